// >>> include/p34_pkg.sv
// Constants and types shared by the port 3 / port 4 pin control logic
package p34_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int AW = 18;
  localparam int DW = 32;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_P4_DATA = 16'hFFD7;
  localparam logic [15:0] IDX_P4_DIR  = 16'hFFE7;
  localparam logic [15:0] IDX_P3_MODE = 16'hFFD0;
  localparam logic [15:0] IDX_P3_DATA = 16'hFFD6;
  localparam logic [15:0] IDX_P3_DIR  = 16'hFFE6;
  localparam logic [15:0] IDX_P3_PU   = 16'hFFE1;

  localparam logic [AW-1:0] ADR_P4_DATA = {IDX_P4_DATA, 2'b00};
  localparam logic [AW-1:0] ADR_P4_DIR  = {IDX_P4_DIR, 2'b00};
  localparam logic [AW-1:0] ADR_P3_MODE = {IDX_P3_MODE, 2'b00};
  localparam logic [AW-1:0] ADR_P3_DATA = {IDX_P3_DATA, 2'b00};
  localparam logic [AW-1:0] ADR_P3_DIR  = {IDX_P3_DIR, 2'b00};
  localparam logic [AW-1:0] ADR_P3_PU   = {IDX_P3_PU, 2'b00};

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_P4_DATA = 8'hF8;
  localparam logic [7:0] RST_P4_DIR  = 8'hF8;
  localparam logic [7:0] RST_P3      = 8'h00;
  localparam logic [7:0] P4_UNUSED   = 8'hF0;
  localparam logic [7:0] ALL_ONES    = 8'hFF;
  localparam int P4_IO_BITS  = 3;
  localparam int P4_IN_BIT   = 3;
  localparam int MODE_CLK    = 0;
  localparam int MODE_SIN    = 1;
  localparam int MODE_SOUT   = 2;

  // ****************************************************************
  // Operating modes of the chip
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_ACTIVE    = 3'h0,
    OP_SUBACTIVE = 3'h1,
    OP_SLEEP     = 3'h3,
    OP_SUBSLEEP  = 3'h2,
    OP_WATCH     = 3'h6,
    OP_STANDBY   = 3'h7
  } p34_opmode_t;

endpackage

// >>> logic/p34_pin_cell.sv
// One pad driver: freezes in low-power modes; in standby floats unless pulled up, then drives high
`timescale 1ns/10ps
`default_nettype none

module p34_pin_cell #(
  parameter bit HAS_PU = 1'b1
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic funcOut,
  input  wire logic funcOe,
  input  wire logic puOn,
  input  wire logic hold,
  input  wire logic park,
  output logic      pinOut,
  output logic      pinOe,
  output logic      pinPu
);

  // ****************************************************************
  // Pad state
  // ****************************************************************
  // reset floats pad
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinOe  <= 1'b0;
      pinOut <= 1'b0;
    end else if (park) begin
      pinOe  <= HAS_PU & puOn;
      pinOut <= 1'b1;
    end else if (!hold) begin
      pinOe  <= funcOe;
      pinOut <= funcOut;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinPu <= 1'b0;
    end else if (!hold) begin
      pinPu <= HAS_PU & puOn;
    end
  end

endmodule

`default_nettype wire

// >>> logic/p34_pin_ctrl.sv
// Port 3 / port 4 pin control with APB register access
//
// Behaviour
// - Port 3 pin 1 becomes serial 1 data input when its select is 1.
// - Port 3 pin 0 is serial clock when selected; source bit sets direction.
// - Port 3 floats in reset, freezes in sleeps and watch, drives pull-up pins high in standby, else works.
// - In standby, port 3 pins with pull-up on present a high level.
// - Port 3 pull-up is on only when direction is 0 and enable is 1.
// - Reset turns all port 3 pull-ups off.
// - Port 4 has three bidirectional pins and one input-only pin.
// - Port 4 data register is 8 bits; bits 2-0 data, bit 3 read-only.
// - Port 4 read of an output pin returns the latched data bit.
// - Port 4 read of an input pin returns the pin level.
// - Port 4 data register resets to F8.
// - Port 4 pins 2-0 drive when direction bit is 1, else input.
// - Port 4 settings apply only while serial 3 leaves the pin general.
// - Port 4 direction register resets to F8.
// - Port 4 direction register is write-only and reads all ones.
// - Port 3 mode: clock select bit 0, input select bit 1, reset 0.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module p34_pin_ctrl
(
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [p34_pkg::AW-1:0] paddr,
  input  wire logic [p34_pkg::DW-1:0] pwdata,
  output logic                       pready,
  output logic [p34_pkg::DW-1:0]     prdata,
  output logic                       pslverr,
  // Chip operating mode
  input  wire p34_pkg::p34_opmode_t  opMode,
  // Serial channel 1 side
  input  wire logic                  serOneClockSource,
  input  wire logic                  serOneClkOut,
  input  wire logic                  serOneDataOut,
  output logic                       serOneClkIn,
  output logic                       serOneDataIn,
  // Serial channel 3 side, one bit per port 4 pin 2..0; pin input covers pins 3..0
  input  wire logic [2:0]            serThreeAltSel,
  input  wire logic [2:0]            serThreeAltOe,
  input  wire logic [2:0]            serThreeAltOut,
  output logic [3:0]                 serThreePinIn,
  // Port 3 pads
  input  wire logic [7:0]            portThreeIn,
  output logic [7:0]                 portThreeOut,
  output logic [7:0]                 portThreeOe,
  output logic [7:0]                 portThreePullup,
  // Port 4 pads
  input  wire logic [3:0]            portFourIn,
  output logic [2:0]                 portFourOut,
  output logic [2:0]                 portFourOe
);

  import p34_pkg::*;

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  logic [7:0] portThreeModeSelect_r;
  logic [7:0] portThreeData_r;
  logic [7:0] portThreeDirection_r;
  logic [7:0] portThreePullupEnable_r;
  logic [2:0] portFourData_r;
  logic [2:0] portFourDirection_r;

  logic       setup;
  logic       wrEn;
  logic       hitP4Data;
  logic       hitP4Dir;
  logic       hitP3Mode;
  logic       hitP3Data;
  logic       hitP3Dir;
  logic       hitP3Pu;
  logic       mapped;
  logic [7:0] rdByte;
  logic [7:0] p4ReadBack;
  logic [7:0] p3ReadBack;

  // Zero-wait slave: decode in setup, complete in the access cycle
  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite & mapped;

  assign hitP4Data = (paddr == ADR_P4_DATA);
  assign hitP4Dir  = (paddr == ADR_P4_DIR);
  assign hitP3Mode = (paddr == ADR_P3_MODE);
  assign hitP3Data = (paddr == ADR_P3_DATA);
  assign hitP3Dir  = (paddr == ADR_P3_DIR);
  assign hitP3Pu   = (paddr == ADR_P3_PU);
  assign mapped    = hitP4Data | hitP4Dir | hitP3Mode |
                     hitP3Data | hitP3Dir | hitP3Pu;

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  logic wrP4Data;
  logic wrP4Dir;
  logic wrP3Mode;
  logic wrP3Data;
  logic wrP3Dir;
  logic wrP3Pu;

  // Writes land at the access edge only; setup loads only prdata and pslverr
  assign wrP4Data = wrEn & hitP4Data;
  assign wrP4Dir  = wrEn & hitP4Dir;
  assign wrP3Mode = wrEn & hitP3Mode;
  assign wrP3Data = wrEn & hitP3Data;
  assign wrP3Dir  = wrEn & hitP3Dir;
  assign wrP3Pu   = wrEn & hitP3Pu;

  // ****************************************************************
  // Port 3 registers
  // ****************************************************************
  // mode selects reset to general I/O
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portThreeModeSelect_r <= RST_P3;
    end else if (wrP3Mode) begin
      portThreeModeSelect_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portThreeData_r <= RST_P3;
    end else if (wrP3Data) begin
      portThreeData_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portThreeDirection_r <= RST_P3;
    end else if (wrP3Dir) begin
      portThreeDirection_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portThreePullupEnable_r <= RST_P3;
    end else if (wrP3Pu) begin
      portThreePullupEnable_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // Port 4 registers
  // ****************************************************************
  // only pins 2-0 stored
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portFourData_r <= RST_P4_DATA[P4_IO_BITS-1:0];
    end else if (wrP4Data) begin
      portFourData_r <= pwdata[P4_IO_BITS-1:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portFourDirection_r <= RST_P4_DIR[P4_IO_BITS-1:0];
    end else if (wrP4Dir) begin
      portFourDirection_r <= pwdata[P4_IO_BITS-1:0];
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // Upper bits read as ones and are never stored
  always_comb begin
    p4ReadBack = P4_UNUSED;
    p4ReadBack[P4_IN_BIT] = portFourIn[P4_IN_BIT];
    for (int i = 0; i < P4_IO_BITS; i++) begin
      p4ReadBack[i] = portFourDirection_r[i] ? portFourData_r[i]
                                             : portFourIn[i];
    end
  end

  // Port 3 read follows the same latch-or-pad choice as port 4
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p3ReadBack[i] = portThreeDirection_r[i] ? portThreeData_r[i]
                                              : portThreeIn[i];
    end
  end

  // Unmapped addresses read as zero and raise pslverr
  always_comb begin
    rdByte = 8'h00;
    unique case (1'b1)
      hitP4Data: rdByte = p4ReadBack;
      hitP4Dir:  rdByte = ALL_ONES;
      hitP3Mode: rdByte = portThreeModeSelect_r;
      hitP3Data: rdByte = p3ReadBack;
      hitP3Dir:  rdByte = portThreeDirection_r;
      hitP3Pu:   rdByte = portThreePullupEnable_r;
      default:   rdByte = 8'h00;
    endcase
  end

  // Read data and error are captured in setup so they come from flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= {24'h000000, pwrite ? 8'h00 : rdByte};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped;
    end
  end

  // ****************************************************************
  // Operating mode decode
  // ****************************************************************
  logic holdPads;
  logic parkPads;

  // Unused mode codes fall through to full function
  // freeze in sleep, sub-sleep and watch modes
  assign holdPads = (opMode == OP_SLEEP) | (opMode == OP_SUBSLEEP) |
                    (opMode == OP_WATCH);
  assign parkPads = (opMode == OP_STANDBY);

  // ****************************************************************
  // Port 3 pin functions
  // ****************************************************************
  logic [7:0] p3FuncOut;
  logic [7:0] p3FuncOe;
  logic [7:0] p3PuOn;

  always_comb begin
    p3FuncOut = portThreeData_r;
    p3FuncOe  = portThreeDirection_r;
    if (portThreeModeSelect_r[MODE_CLK]) begin
      p3FuncOut[0] = serOneClkOut;
      p3FuncOe[0]  = ~serOneClockSource;
    end
    if (portThreeModeSelect_r[MODE_SIN]) begin
      p3FuncOut[1] = 1'b0;
      p3FuncOe[1]  = 1'b0;
    end
    if (portThreeModeSelect_r[MODE_SOUT]) begin
      p3FuncOut[2] = serOneDataOut;
      p3FuncOe[2]  = 1'b1;
    end
  end

  // Pull-up ignores which function owns the pin
  // pull-up only on inputs
  assign p3PuOn = ~portThreeDirection_r & portThreePullupEnable_r;

  // Serial side sees the pad only while the pin is handed to it
  // data input routed
  assign serOneDataIn = portThreeModeSelect_r[MODE_SIN] & portThreeIn[1];
  assign serOneClkIn  = portThreeModeSelect_r[MODE_CLK] &
                        serOneClockSource & portThreeIn[0];

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gP3
      p34_pin_cell #(.HAS_PU(1'b1)) uCell (
        .mclk    (mclk),
        .nrst    (nrst),
        .funcOut (p3FuncOut[g]),
        .funcOe  (p3FuncOe[g]),
        .puOn    (p3PuOn[g]),
        .hold    (holdPads),
        .park    (parkPads),
        .pinOut  (portThreeOut[g]),
        .pinOe   (portThreeOe[g]),
        .pinPu   (portThreePullup[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Port 4 pin functions
  // ****************************************************************
  logic [2:0] p4FuncOut;
  logic [2:0] p4FuncOe;

  always_comb begin
    for (int i = 0; i < P4_IO_BITS; i++) begin
      // Ownership overrides both direction and data
      // serial 3 owns pin
      p4FuncOut[i] = serThreeAltSel[i] ? serThreeAltOut[i]
                                       : portFourData_r[i];
      p4FuncOe[i]  = serThreeAltSel[i] ? serThreeAltOe[i]
                                       : portFourDirection_r[i];
    end
  end

  assign serThreePinIn = portFourIn;

  // Pin 3 is input only, so it needs no pad cell
  generate
    for (g = 0; g < P4_IO_BITS; g++) begin : gP4
      p34_pin_cell #(.HAS_PU(1'b0)) uCell (
        .mclk    (mclk),
        .nrst    (nrst),
        .funcOut (p4FuncOut[g]),
        .funcOe  (p4FuncOe[g]),
        .puOn    (1'b0),
        .hold    (holdPads),
        .park    (parkPads),
        .pinOut  (portFourOut[g]),
        .pinOe   (portFourOe[g]),
        .pinPu   ()
      );
    end
  endgenerate

endmodule

`default_nettype wire

// >>> tb/p34_pin_ctrl_asserts.sv
// Port-level assertions for the port 3 / port 4 pin control block
`timescale 1ns/10ps
`default_nettype none

module p34_pin_ctrl_asserts
  import p34_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    nrst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [p34_pkg::AW-1:0]  paddr,
  input wire logic [p34_pkg::DW-1:0]  prdata,
  input wire logic                    pslverr,
  input wire p34_pkg::p34_opmode_t    opMode,
  input wire logic                    serOneClockSource,
  input wire logic                    serOneClkIn,
  input wire logic                    serOneDataIn,
  input wire logic [2:0]              serThreeAltSel,
  input wire logic [2:0]              serThreeAltOe,
  input wire logic [7:0]              portThreeIn,
  input wire logic [7:0]              portThreeOut,
  input wire logic [7:0]              portThreeOe,
  input wire logic [7:0]              portThreePullup,
  input wire logic [3:0]              portFourIn,
  input wire logic [2:0]              portFourOut,
  input wire logic [2:0]              portFourOe
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic lowPow;
  logic rdAcc;
  logic rstSeen;

  // Skips the first reset edge, before the async clear is certain
  always_ff @(posedge mclk) begin
    rstSeen <= !nrst;
  end
  assign lowPow = opMode inside {OP_SLEEP, OP_SUBSLEEP, OP_WATCH};
  assign rdAcc  = psel && penable && !pwrite;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // Properties
  // ****************************************************************
  pads_frozen_a: assert property (
    $past(nrst) && $past(lowPow) |-> $stable(portThreeOut) &&
    $stable(portThreeOe) && $stable(portFourOut) && $stable(portFourOe))
    else $error("pads moved in a retaining mode");
  standby_float_a: assert property (
    $past(nrst) && $past(opMode) == OP_STANDBY && opMode == OP_STANDBY
    |-> portFourOe == 3'h0) else $error("port 4 driven in standby");
  standby_high_a: assert property (
    $past(nrst) && $past(opMode) == OP_STANDBY && opMode == OP_STANDBY
    |-> portThreeOe == portThreePullup && (portThreeOut & portThreeOe)
    == portThreeOe) else $error("standby pull-up pin not high");
  reset_float_a: assert property (disable iff (1'b0)
    !nrst && rstSeen |-> portThreeOe == 8'h00 && portFourOe == 3'h0 &&
    portThreePullup == 8'h00) else $error("pads active in reset");
  pullup_dir_a: assert property (
    $past(opMode) == OP_ACTIVE |->
    (portThreePullup[7:3] & portThreeOe[7:3]) == 5'h00)
    else $error("pull-up on a driven pin");
  owned_pins_a: assert property (
    $past(nrst) && opMode == OP_ACTIVE && $past(opMode) == OP_ACTIVE |->
    (portFourOe & $past(serThreeAltSel)) ==
    ($past(serThreeAltOe) & $past(serThreeAltSel)))
    else $error("owned port 4 pin not steered by serial 3");
  clk_in_a: assert property (
    serOneClkIn |-> serOneClockSource && portThreeIn[0])
    else $error("serial clock input wrongly routed");
  data_in_a: assert property (
    serOneDataIn |-> portThreeIn[1]) else $error("serial data in wrong");
  dir_ones_a: assert property (
    rdAcc && paddr == ADR_P4_DIR |-> prdata[7:0] == ALL_ONES && !pslverr)
    else $error("direction read not all ones");
  upper_ones_a: assert property (
    rdAcc && paddr == ADR_P4_DATA |-> prdata[7:4] == 4'hF)
    else $error("port 4 upper bits not one");
  pin3_read_a: assert property (
    (psel && !penable && !pwrite && paddr == ADR_P4_DATA) ##1 rdAcc
    |-> prdata[3] == $past(portFourIn[3])) else $error("bit 3 not pin");
endmodule

bind p34_pin_ctrl p34_pin_ctrl_asserts u_chk (.mclk, .nrst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pslverr, .opMode,
  .serOneClockSource, .serOneClkIn, .serOneDataIn, .serThreeAltSel,
  .serThreeAltOe, .portThreeIn, .portThreeOut, .portThreeOe,
  .portThreePullup, .portFourIn, .portFourOut, .portFourOe);

`default_nettype wire

// >>> tb/p34_pin_ctrl_tb.sv
// Self-checking bench for the port 3 / port 4 pin control block
`timescale 1ns/10ps
`default_nettype none

module p34_pin_ctrl_tb;
  import p34_pkg::*;
  logic              mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]     paddr;
  logic [DW-1:0]     pwdata, prdata;
  p34_opmode_t       opMode;
  logic              serOneClockSource, serOneClkOut, serOneDataOut;
  logic              serOneClkIn, serOneDataIn;
  logic [2:0]        serThreeAltSel, serThreeAltOe, serThreeAltOut;
  logic [2:0]        portFourOut, portFourOe;
  logic [3:0]        serThreePinIn, portFourIn;
  logic [7:0]        portThreeIn, portThreeOut, portThreeOe, portThreePullup;
  logic [8:0]        expQ[$];
  logic [7:0]        d, w, u;
  int                errTotal = 0;
  int                compares = 0;
  p34_opmode_t       lpMode[3] = '{OP_SLEEP, OP_SUBSLEEP, OP_WATCH};

  p34_pin_ctrl dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .opMode, .serOneClockSource, .serOneClkOut,
    .serOneDataOut, .serOneClkIn, .serOneDataIn, .serThreeAltSel,
    .serThreeAltOe, .serThreeAltOut, .serThreePinIn, .portThreeIn,
    .portThreeOut, .portThreeOe, .portThreePullup, .portFourIn,
    .portFourOut, .portFourOe);

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Expected port 4 read: latch where output, pin where input
  function automatic logic [8:0] p4exp(input logic [7:0] dr,
                                       input logic [7:0] dt,
                                       input logic [3:0] pin);
    return {1'b0, 4'hF, pin[3], (dr[2:0] & dt[2:0]) | (~dr[2:0] & pin[2:0])};
  endfunction

  // ****************************************************************
  // APB master; reads queue the expected {pslverr, data} before the access
  // ****************************************************************
  task automatic apb(input logic wr, input logic [AW-1:0] a,
                     input logic [7:0] dat, input logic [8:0] ex);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, dat};
    if (!wr) expQ.push_back(ex);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata[7:0]}, expQ.pop_front());
    end
  end

  // ****************************************************************
  // Clock, watchdog, tests
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // A few hundred cycles are expected; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    tally_and_finish;
  end

  initial begin
    {nrst, psel, penable, pwrite} = 4'h0;
    {serOneClockSource, serOneClkOut, serOneDataOut} = 3'h0;
    paddr = '0;
    pwdata = '0;
    opMode = OP_ACTIVE;
    {serThreeAltSel, serThreeAltOe, serThreeAltOut} = 9'h000;
    portThreeIn = 8'h00;
    portFourIn = 4'h8;
    void'($urandom(30));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    chk(portThreePullup, 8'h00);
    chk(portFourOe, 3'h0);
    apb(1'b0, ADR_P4_DATA, 8'h00, 9'h0F8);
    apb(1'b0, ADR_P4_DIR, 8'h00, 9'h0FF);
    apb(1'b0, ADR_P3_MODE, 8'h00, 9'h000);
    apb(1'b0, 18'h00010, 8'h00, 9'h100);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      w = 8'($urandom);
      u = 8'($urandom);
      portFourIn <= u[3:0];
      apb(1'b1, ADR_P4_DIR, d, 9'h000);
      apb(1'b1, ADR_P4_DATA, w, 9'h000);
      apb(1'b0, ADR_P4_DIR, 8'h00, 9'h0FF);
      apb(1'b0, ADR_P4_DATA, 8'h00, p4exp(d, w, u[3:0]));
      repeat (2) @(posedge mclk);
      chk(portFourOe, d[2:0]);
      chk(portFourOut & d[2:0], w[2:0] & d[2:0]);
      chk(serThreePinIn, u[3:0]);
    end
    serThreeAltSel <= 3'b101;
    serThreeAltOe  <= 3'b001;
    serThreeAltOut <= 3'b100;
    repeat (3) @(posedge mclk);
    chk(portFourOe, {1'b0, d[1], 1'b1});
    chk(portFourOut[0], 1'b0);
    serThreeAltSel <= 3'b000;
    $display("Test port 4 data and direction done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      w = 8'($urandom);
      apb(1'b1, ADR_P3_DIR, d, 9'h000);
      apb(1'b1, ADR_P3_PU, w, 9'h000);
      repeat (2) @(posedge mclk);
      chk(portThreePullup, ~d & w);
    end
    $display("Test port 3 pull-ups done");
    portThreeIn <= 8'h03;
    serOneClockSource <= 1'b1;
    serOneDataOut <= 1'b1;
    apb(1'b1, ADR_P3_MODE, 8'h07, 9'h000);
    apb(1'b0, ADR_P3_MODE, 8'h00, 9'h007);
    chk({portThreeOe[2:1], portThreeOut[2]}, 3'b101);
    chk(serOneDataIn, 1'b1);
    chk(serOneClkIn, 1'b1);
    serOneClockSource <= 1'b0;
    serOneClkOut <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({portThreeOe[0], portThreeOut[0], serOneClkIn}, 3'b110);
    apb(1'b1, ADR_P3_MODE, 8'h00, 9'h000);
    @(posedge mclk);
    chk(serOneDataIn, 1'b0);
    $display("Test serial pin selection done");
    apb(1'b1, ADR_P4_DIR, 8'h07, 9'h000);
    apb(1'b1, ADR_P4_DATA, 8'h00, 9'h000);
    apb(1'b1, ADR_P3_DIR, 8'h0F, 9'h000);
    apb(1'b1, ADR_P3_PU, 8'hF0, 9'h000);
    for (int k = 0; k < 3; k++) begin
      opMode <= lpMode[k];
      apb(1'b1, ADR_P4_DATA, 8'(k + 1), 9'h000);
      repeat (2) @(posedge mclk);
      chk(portFourOut, 3'(k));
      opMode <= (k == 1) ? OP_SUBACTIVE : OP_ACTIVE;
      repeat (3) @(posedge mclk);
      chk(portFourOut, 3'(k + 1));
    end
    opMode <= OP_STANDBY;
    repeat (3) @(posedge mclk);
    chk(portFourOe, 3'h0);
    chk(portThreeOe, 8'hF0);
    chk(portThreeOut & 8'hF0, 8'hF0);
    opMode <= OP_ACTIVE;
    $display("Test operating modes done");
    repeat (2) @(posedge mclk);
    nrst <= 1'b0;
    portFourIn <= 4'h8;
    repeat (2) @(posedge mclk);
    chk({portThreePullup, portThreeOe}, 16'h0000);
    nrst <= 1'b1;
    apb(1'b0, ADR_P4_DATA, 8'h00, 9'h0F8);
    apb(1'b0, ADR_P3_PU, 8'h00, 9'h000);
    $display("Test mid-run reset done");
    repeat (2) @(posedge mclk);
    tally_and_finish;
  end
endmodule

`default_nettype wire
